// >>> common/sar_port_params.svh
`ifndef SAR_PORT_PARAMS_SVH
`define SAR_PORT_PARAMS_SVH

// Core clock
`define CLK_PERIOD_NS 8

// Frame layout in serial clock falling edges
`define CMD_EDGES 16
`define RES_BITS 16

// Conversion time on the core clock
`define CONV_TIME_NS 800

// Reset/power-down pin low-time classes
`define RST_MIN_NS 40
`define RST_MAX_NS 100
`define PD_MIN_NS 400

// Command word fields
`define CHAN_MSB 12
`define CHAN_LSB 10
`define CMD_HOLD 16'h0000
`define CHAN_RESET 3'h0

// Word returned while no valid result exists
`define INVALID_WORD 16'hFFFF

`endif

// >>> common/sar_port_pkg.sv
`default_nettype none
package sar_port_pkg;
  // Operating state of the converter core
  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_INVALID, ST_PWRDN} mode_t;
  typedef logic [15:0] word_t;
  typedef logic [2:0] chan_t;
endpackage
`default_nettype wire

// >>> rtl/sync_2ff.sv
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Data
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= RST_VAL;
      o_q <= RST_VAL;
    end
    else
    begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/rst_pin_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "sar_port_params.svh"
module rst_pin_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Synchronised pin level, high while the pin is low
  input wire logic i_pin_low,
  // Results
  output logic o_reg_reset,
  output logic o_power_down
);
  // Least times round up, longest rounds down
  localparam int RST_MIN_CYC = (`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int RST_MAX_CYC = `RST_MAX_NS / `CLK_PERIOD_NS;
  localparam int PD_CYC = (`PD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [6:0] RST_MIN_C = 7'(RST_MIN_CYC);
  localparam logic [6:0] PD_C = 7'(PD_CYC);

  logic [6:0] low_cnt_q;
  logic pin_low_q;
  wire logic released = pin_low_q && !i_pin_low;
  wire logic long_enough = low_cnt_q > RST_MIN_C;

  // Saturating low-time counter; short glitches are ignored
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      low_cnt_q <= 7'h00;
      pin_low_q <= 1'b0;
      o_reg_reset <= 1'b0;
      o_power_down <= 1'b0;
    end
    else
    begin
      pin_low_q <= i_pin_low;
      if (!i_pin_low)
        low_cnt_q <= 7'h00;
      else if (low_cnt_q != PD_C)
        low_cnt_q <= low_cnt_q + 7'h01;
      o_reg_reset <= released && long_enough;
      if (i_pin_low && low_cnt_q == PD_C)
        o_power_down <= 1'b1;
      else if (!i_pin_low)
        o_power_down <= 1'b0;
    end
  end

  // Mid-length pulses reset only; power-down needs the full hold
  property p_pd_entry;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_pin_low && low_cnt_q == PD_C) |=> o_power_down;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

  property p_short_no_pd;
    @(posedge i_clk) disable iff (!i_rst_n)
    (released && low_cnt_q <= 7'(RST_MAX_CYC)) |-> !o_power_down;
  endproperty
  a_short_no_pd: assert property (p_short_no_pd) else $error("short pulse powered down");
endmodule
`default_nettype wire

// >>> rtl/sar_frame_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "sar_port_params.svh"
module sar_frame_port (
  // Core clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Serial frame link
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_daisy,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  // Reset/power-down pin
  input wire logic i_reset_powerdown_pin_n,
  // Converter core
  input wire sar_port_pkg::word_t i_conv_result,
  output logic o_sample,
  output sar_port_pkg::chan_t o_mux_sel,
  // Status
  output logic o_regs_reset,
  output logic o_power_down,
  output sar_port_pkg::mode_t o_mode
);
  import sar_port_pkg::*;
  localparam int CONV_CYC = (`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [7:0] CONV_C = 8'(CONV_CYC);
  localparam logic [5:0] LAST_CMD_CNT = 6'(`CMD_EDGES - 1);
  localparam logic [5:0] CNT_MAX = 6'h3F;

  // Link domain, serial clock falling edge
  logic [5:0] edge_cnt_q;
  logic [15:0] cmd_sh_q;
  logic [15:0] out_sh_q;
  logic sdo_q;
  word_t cmd_word_q;
  logic cmd_tgl_q;
  logic [1:0] link_sync;
  wire logic pd_link = link_sync[1];
  wire logic done_link = link_sync[0];
  logic conv_done_q;
  logic pd_core;

  // Done and power-down levels into the link domain
  sync_2ff #(.WIDTH(2), .RST_VAL(2'b00)) u_link_sync (
    .i_clk(!i_sclk),
    .i_rst_n(i_rst_n),
    .i_d({pd_core, conv_done_q}),
    .o_q(link_sync)
  );

  wire logic in_cmd = edge_cnt_q <= LAST_CMD_CNT;
  wire logic last_cmd = edge_cnt_q == LAST_CMD_CNT;
  wire logic in_shift = edge_cnt_q > LAST_CMD_CNT;
  word_t core_word_q;
  // Result only if the core finished; else the marked invalid word
  wire word_t load_word = done_link ? core_word_q : `INVALID_WORD;

  // Frame-local state, cleared while chip select is high
  always_ff @(negedge i_sclk or posedge i_cs_n or negedge i_rst_n)
  begin
    if (!i_rst_n || i_cs_n)
    begin
      edge_cnt_q <= 6'h00;
      cmd_sh_q <= 16'h0000;
      out_sh_q <= 16'h0000;
      sdo_q <= 1'b0;
    end
    else if (!pd_link)
    begin
      if (edge_cnt_q != CNT_MAX)
        edge_cnt_q <= edge_cnt_q + 6'h01;
      if (in_cmd)
        cmd_sh_q <= {cmd_sh_q[14:0], i_sdi};
      if (last_cmd)
      begin
        out_sh_q <= load_word;
        sdo_q <= load_word[15];
      end
      else if (in_shift)
      begin
        out_sh_q <= {out_sh_q[14:0], i_daisy};
        sdo_q <= out_sh_q[14];
      end
    end
  end

  // Completed command word and its event toggle persist across frames
  always_ff @(negedge i_sclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cmd_word_q <= `CMD_HOLD;
      cmd_tgl_q <= 1'b0;
    end
    else if (!i_cs_n && !pd_link && last_cmd)
    begin
      cmd_word_q <= {cmd_sh_q[14:0], i_sdi};
      cmd_tgl_q <= !cmd_tgl_q;
    end
  end

  // Pin released to high impedance outside frames and in power-down
  assign o_sdo = sdo_q;
  // Core level covers the first edges, before the parked-clock synchroniser catches up
  assign o_sdo_oe_n = i_cs_n || pd_link || pd_core;

  // Core domain, internal oscillator
  logic [2:0] core_sync;
  sync_2ff #(.WIDTH(3), .RST_VAL(3'b011)) u_core_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({cmd_tgl_q, i_reset_powerdown_pin_n, i_cs_n}),
    .o_q(core_sync)
  );
  wire logic cs_n_s = core_sync[0];
  wire logic pin_low_s = !core_sync[1];
  wire logic tgl_s = core_sync[2];

  logic regs_reset;
  rst_pin_timer u_rst_pin_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin_low(pin_low_s),
    .o_reg_reset(regs_reset),
    .o_power_down(pd_core)
  );

  mode_t mode_q;
  mode_t mode_d;
  logic cs_n_q;
  logic tgl_q;
  logic got_cmd_q;
  logic pend_q;
  word_t pend_word_q;
  chan_t chan_q;
  chan_t chan_d;
  logic [7:0] conv_cnt_q;
  word_t result_q;

  // Edges taken from synchroniser outputs only
  wire logic cs_fall = cs_n_q && !cs_n_s;
  wire logic cs_rise = !cs_n_q && cs_n_s;
  wire logic cmd_evt = tgl_q != tgl_s;
  wire logic pend_hold = pend_word_q == `CMD_HOLD;
  wire logic apply_cmd = cs_fall && pend_q && !pend_hold;
  wire logic pin_busy = pin_low_s || pd_core;
  wire logic start_conv = cs_fall && !pin_busy && mode_d == ST_ACTIVE;

  // Next channel, and the converted one that register resets clear
  assign chan_d = apply_cmd ? pend_word_q[`CHAN_MSB:`CHAN_LSB] : chan_q;
  wire chan_t mux_sel_d = start_conv ? chan_d : (regs_reset || pd_core) ? `CHAN_RESET : o_mux_sel;

  // Mode selection
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      ST_PWRDN:
        if (!pd_core)
          mode_d = ST_IDLE;
      ST_IDLE, ST_ACTIVE, ST_INVALID:
        if (apply_cmd)
          mode_d = ST_ACTIVE;
        else if (cs_rise && !got_cmd_q && !cmd_evt)
          mode_d = ST_INVALID;
      default:
        mode_d = ST_IDLE;
    endcase
    if (pd_core)
      mode_d = ST_PWRDN;
    else if (regs_reset)
      mode_d = ST_IDLE;
  end

  // Mode, command bookkeeping and channel
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_q <= ST_IDLE;
      cs_n_q <= 1'b1;
      tgl_q <= 1'b0;
      got_cmd_q <= 1'b0;
      pend_q <= 1'b0;
      pend_word_q <= `CMD_HOLD;
      chan_q <= `CHAN_RESET;
    end
    else
    begin
      mode_q <= mode_d;
      cs_n_q <= cs_n_s;
      tgl_q <= tgl_s;
      if (cmd_evt)
        got_cmd_q <= 1'b1; // Set wins over the frame-start clear
      else if (cs_fall)
        got_cmd_q <= 1'b0;
      if (cmd_evt && !pin_busy)
      begin
        pend_q <= 1'b1;
        pend_word_q <= cmd_word_q; // Word stable until next frame's edge 16
      end
      else if (cs_fall || regs_reset || pd_core)
        pend_q <= 1'b0;
      chan_q <= (regs_reset || pd_core) ? `CHAN_RESET : chan_d;
    end
  end

  // Conversion timing and result capture
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      conv_cnt_q <= 8'h00;
      conv_done_q <= 1'b0;
      result_q <= 16'h0000;
      o_sample <= 1'b0;
      o_mux_sel <= `CHAN_RESET;
    end
    else
    begin
      o_sample <= start_conv;
      o_mux_sel <= mux_sel_d;
      if (start_conv)
      begin
        conv_cnt_q <= CONV_C;
        conv_done_q <= 1'b0;
      end
      else if (cs_fall || pin_busy)
        conv_done_q <= 1'b0;
      else if (conv_cnt_q == 8'h01)
      begin
        conv_cnt_q <= 8'h00;
        result_q <= i_conv_result;
        conv_done_q <= 1'b1;
      end
      else if (conv_cnt_q != 8'h00)
        conv_cnt_q <= conv_cnt_q - 8'h01;
    end
  end

  // Invalid state returns the marked word instead of the result
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      core_word_q <= `INVALID_WORD;
    else
      core_word_q <= (mode_q == ST_INVALID) ? `INVALID_WORD : result_q;
  end

  assign o_regs_reset = regs_reset;
  assign o_power_down = pd_core;
  assign o_mode = mode_q;

  property p_sdo_low_early;
    @(negedge i_sclk) disable iff (!i_rst_n || i_cs_n)
    (edge_cnt_q <= LAST_CMD_CNT) |-> !sdo_q;
  endproperty
  a_sdo_low_early: assert property (p_sdo_low_early) else $error("output not low early");

  property p_msb_at_16;
    @(negedge i_sclk) disable iff (!i_rst_n || i_cs_n)
    (last_cmd && !pd_link) |=> sdo_q == $past(load_word[15]);
  endproperty
  a_msb_at_16: assert property (p_msb_at_16) else $error("MSB not on edge 16");

  property p_chain_shift;
    @(negedge i_sclk) disable iff (!i_rst_n || i_cs_n)
    (in_shift && !pd_link) |=> out_sh_q[0] == $past(i_daisy) && sdo_q == $past(out_sh_q[14]);
  endproperty
  a_chain_shift: assert property (p_chain_shift) else $error("chain shift wrong");

  property p_cmd_capture;
    @(negedge i_sclk) disable iff (!i_rst_n || i_cs_n)
    (in_cmd && !pd_link) |=> cmd_sh_q[0] == $past(i_sdi);
  endproperty
  a_cmd_capture: assert property (p_cmd_capture) else $error("command bit missed");

  property p_cmd_frozen;
    @(negedge i_sclk) disable iff (!i_rst_n || i_cs_n)
    in_shift |=> cmd_word_q == $past(cmd_word_q);
  endproperty
  a_cmd_frozen: assert property (p_cmd_frozen) else $error("command changed late");

  property p_conv_channel;
    @(posedge i_clk) disable iff (!i_rst_n)
    start_conv |=> o_sample && o_mux_sel == $past(chan_d) ##1 !o_sample;
  endproperty
  a_conv_channel: assert property (p_conv_channel) else $error("wrong channel sampled");

  property p_result_load;
    @(posedge i_clk) disable iff (!i_rst_n)
    (conv_cnt_q == 8'h01 && !start_conv && !cs_fall && !pin_busy)
      |=> conv_done_q && result_q == $past(i_conv_result);
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded");

  property p_abort;
    @(posedge i_clk) disable iff (!i_rst_n)
    (cs_rise && !got_cmd_q && !cmd_evt && !pin_busy && !regs_reset && mode_q != ST_PWRDN)
      |=> mode_q == ST_INVALID ##1 core_word_q == `INVALID_WORD;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not flagged");

  property p_idle_quiet;
    @(posedge i_clk) disable iff (!i_rst_n)
    (mode_q != ST_ACTIVE && !apply_cmd) |=> !o_sample;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("conversion while idle");
  property p_hold_cmd;
    @(posedge i_clk) disable iff (!i_rst_n)
    (cs_fall && pend_q && pend_hold && !regs_reset && !pd_core) |=> chan_q == $past(chan_q);
  endproperty
  a_hold_cmd: assert property (p_hold_cmd) else $error("hold command changed channel");
endmodule
`default_nettype wire

// >>> tb/sar_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sar_host_model
  import sar_port_pkg::*;
(
  // Frame lines to the device
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  output logic o_daisy,
  // Returned data
  input wire logic i_sdo
);
  // Deselected, clock parked high between frames
  initial
  begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
    o_daisy = 1'b0;
  end

  // One frame of n edges; a short lead breaks the conversion time on purpose
  task automatic frame(input word_t cmd, input word_t up, input int n, input int lead,
                       output logic [47:0] rx);
    int e;
    rx = '0;
    #3 o_cs_n = 1'b0;
    #(lead);
    for (e = 1; e <= n; e++)
    begin
      // Command MSB first, then a toggling line the device must ignore
      o_sdi = (e <= 16) ? cmd[16-e] : ~o_sdi;
      // Upstream device in a chain: its word from edge 17, then low
      o_daisy = (e >= 17 && e <= 32) ? up[32-e] : 1'b0;
      #24 o_sclk = 1'b0;
      #24 o_sclk = 1'b1;
      rx = {rx[46:0], i_sdo};
    end
    o_cs_n = 1'b1;
    // Released lines must not keep their last value
    o_sdi = ~o_sdi;
    o_daisy = ~o_daisy;
    // Deselect gap long enough for the core synchroniser to see it
    #40;
  endtask
endmodule
`default_nettype wire

// >>> tb/sar_frame_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "sar_port_params.svh"
module sar_frame_port_tb;
  import sar_port_pkg::*;
  typedef struct packed {word_t cmd; word_t res; word_t up;} row_t;
  logic clk, rst_n, reset_powerdown_pin_n, pd;
  logic sclk, cs_n, host_to_device_line, daisy, device_to_host_line, sdo_oe_n, sample, regs_reset, power_down;
  word_t conv_result;
  chan_t mux_sel, ch;
  mode_t mode;
  logic [47:0] rx;
  int fail_count, check_count, sample_cnt, rst_cnt, s0, i;
  // Every channel, a hold word in mid-run, chain words at the boundaries
  row_t rows[9] = '{
    '{16'h8400, 16'hA5C3, 16'h0000}, '{16'h0000, 16'h8001, 16'hFFFF},
    '{16'h8800, 16'h7FFE, 16'h8001}, '{16'h8C00, 16'hFFFF, 16'h1234},
    '{16'h9000, 16'h0001, 16'h8000}, '{16'h9400, 16'h5A5A, 16'h0001},
    '{16'h9800, 16'h0000, 16'hC3A5}, '{16'h9C00, 16'h1357, 16'h0F0F},
    '{16'h8000, 16'hFEDC, 16'h2468}};

  sar_frame_port i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(host_to_device_line), .i_daisy(daisy), .o_sdo(device_to_host_line), .o_sdo_oe_n(sdo_oe_n),
    .i_reset_powerdown_pin_n(reset_powerdown_pin_n), .i_conv_result(conv_result), .o_sample(sample),
    .o_mux_sel(mux_sel), .o_regs_reset(regs_reset), .o_power_down(power_down),
    .o_mode(mode));

  sar_host_model i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(host_to_device_line), .o_daisy(daisy),
    .i_sdo(device_to_host_line));

  // Core clock, 8 ns
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("BAD t=%0t %s", $time, what);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Pulse counters; one-cycle pulses are seen only at the edge
  always @(posedge clk)
  begin
    if (sample === 1'b1)
      sample_cnt++;
    if (regs_reset === 1'b1)
      rst_cnt++;
  end

  // Driver enable inside a frame: driving unless powered down
  always @(negedge sclk)
    if (cs_n === 1'b0)
      check(sdo_oe_n === pd, "output enable in frame");

  // Hang guard, well beyond the expected 37 us
  initial
  begin
    #300000;
    fail_count++;
    wrap_up();
  end

  initial
  begin
    rst_n = 1'b0;
    reset_powerdown_pin_n = 1'b1;
    conv_result = 16'h0000;
    pd = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    check(mode === ST_IDLE && mux_sel === 3'h0 && sample_cnt == 0, "idle");
    // Priming frame picks the first channel
    i_host.frame(16'h9C00, 16'h0000, 48, 200, rx);
    ch = 3'h7;
    for (i = 0; i < 9; i++)
    begin
      @(posedge clk);
      conv_result <= rows[i].res;
      s0 = sample_cnt;
      i_host.frame(rows[i].cmd, rows[i].up, 48, 200, rx);
      check(rx === {15'h0000, rows[i].res, rows[i].up, 1'b0}, "frame data");
      check(mux_sel === ch, "channel");
      check(sample_cnt == s0 + 1 && sdo_oe_n === 1'b1, "sample, release");
      if (rows[i].cmd != 16'h0000)
        ch = rows[i].cmd[12:10];
    end
    // Abort after 8 edges, then a good command still returns invalid data
    i_host.frame(16'h9000, 16'h0000, 8, 200, rx);
    check(mode === ST_INVALID, "abort mode");
    i_host.frame(16'h9000, 16'h0000, 48, 200, rx);
    check(rx[32:17] === `INVALID_WORD, "abort data");
    // Sixteenth edge before conversion end
    @(posedge clk);
    conv_result <= 16'h1234;
    i_host.frame(16'h0000, 16'h0000, 48, 0, rx);
    check(rx[32:17] === `INVALID_WORD, "early edge");
    i_host.frame(16'h0000, 16'h0000, 48, 200, rx);
    check(rx[32:17] === 16'h1234 && mux_sel === 3'h4, "recovered");
    // Short pin pulse, 80 ns
    s0 = rst_cnt;
    @(posedge clk);
    reset_powerdown_pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_powerdown_pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    check(rst_cnt == s0 + 1 && power_down === 1'b0, "short pulse");
    check(mode === ST_IDLE && mux_sel === 3'h0, "short pulse state");
    // Long pin hold, 480 ns to the power-down check, then a frame while down
    reset_powerdown_pin_n <= 1'b0;
    repeat (60) @(posedge clk);
    check(power_down === 1'b1, "power down");
    pd = 1'b1;
    s0 = sample_cnt;
    i_host.frame(16'h8800, 16'h0000, 48, 200, rx);
    check(sample_cnt == s0 && power_down === 1'b1, "inputs ignored");
    pd = 1'b0;
    s0 = rst_cnt;
    @(posedge clk);
    reset_powerdown_pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    check(power_down === 1'b0 && rst_cnt == s0 + 1, "wake");
    check(mode === ST_IDLE && mux_sel === 3'h0, "wake state");
    wrap_up();
  end
endmodule
`default_nettype wire
